// File: hdl/ov_fault_response.sv
// Output overvoltage fault response: setting register, status flags, alert and power control.
`timescale 1ns/1ps
`default_nettype none
module ov_fault_response
	import ov_resp_pkg::*;
#(
	parameter int unsigned RETRY_W = 24
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic resp_wr_i,
	input wire logic [7:0] resp_wdata_i,
	input wire logic [RETRY_W-1:0] retry_interval_setting_i,
	input wire logic decay_check_en_i,
	input wire logic output_decayed_i,
	input wire logic ov_detect_i,
	input wire logic clear_faults_i,
	input wire logic output_commanded_on_i,
	input wire logic other_latch_fault_i,
	output logic [7:0] output_overvoltage_response_o,
	output ov_flags_t flags_o,
	output logic alert_o,
	output logic cml_fault_o,
	output power_ctl_t power_o,
	output logic overvoltage_low_side_clamp_o
);
	typedef struct packed {
		logic [7:0] resp;
		ov_flags_t flags;
		logic alert;
		logic cml;
		ov_state_t st;
		logic cmd_on_d;
		logic disable_out;
		logic restart;
		logic interval_done;
	} ov_top_state_t;

	ov_top_state_t s;
	ov_top_state_t next_s;
	logic [1:0] resp_mode;
	logic [2:0] retry_mode;
	logic wr_valid;
	logic off_to_on;
	logic dgl_start;
	logic dgl_done;
	logic rty_start;
	logic rty_done;

	assign resp_mode = s.resp[RESP_FIELD_MSB -: 2];
	assign retry_mode = s.resp[RETRY_FIELD_MSB -: 3];
	assign off_to_on = output_commanded_on_i && !s.cmd_on_d;

	// Only the documented encodings are accepted; everything else is refused.
	always_comb begin
		wr_valid = (resp_wdata_i == RESP_CLAMP) || (resp_wdata_i == RESP_LATCH)
			|| (resp_wdata_i == RESP_RETRY)
			|| (resp_wdata_i[7:3] == RESP_DGL_LATCH_HI)
			|| (resp_wdata_i[7:3] == RESP_DGL_RETRY_HI);
	end

	assign dgl_start = (s.st == ST_RUN) && ov_detect_i && (resp_mode == MODE_DEGLITCH);
	assign rty_start = (s.st != ST_RETRY_WAIT) && (next_s.st == ST_RETRY_WAIT);

	ov_unit_timer #(
		.UNIT_CYC(DELAY_UNIT_CYC),
		.COUNT_W(3)
	) u_deglitch (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.start_i(dgl_start),
		.units_i(s.resp[DELAY_FIELD_MSB:0]),
		.done_o(dgl_done),
		.busy_o()
	);

	ov_unit_timer #(
		.UNIT_CYC(RETRY_UNIT_CYC),
		.COUNT_W(RETRY_W)
	) u_retry (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.start_i(rty_start),
		.units_i(retry_interval_setting_i),
		.done_o(rty_done),
		.busy_o()
	);

	always_comb begin
		next_s = s;
		next_s.cml = 1'b0;
		next_s.restart = 1'b0;
		next_s.cmd_on_d = output_commanded_on_i;
		if (resp_wr_i) begin
			if (wr_valid) begin
				next_s.resp = resp_wdata_i;
			end else begin
				next_s.cml = 1'b1; // [R10] [R11]
			end
		end
		// Clears come first so that a fault in the same cycle still sets the flags.
		if (clear_faults_i || off_to_on) begin
			next_s.flags = '0; // [R12]
			next_s.alert = 1'b0;
		end
		if (ov_detect_i) begin
			next_s.flags.status_byte_ov = 1'b1; // [R1]
			next_s.flags.status_word_vout = 1'b1; // [R2]
			next_s.flags.status_vout_ov = 1'b1; // [R3]
			next_s.alert = 1'b1; // [R4]
		end
		if (rty_done) begin
			next_s.interval_done = 1'b1;
		end
		unique case (s.st)
			ST_RUN: begin
				next_s.disable_out = 1'b0;
				if (ov_detect_i && output_commanded_on_i) begin
					if (resp_mode == MODE_DEGLITCH) begin
						next_s.st = ST_DEGLITCH; // [R13] [R17]
					end else if (resp_mode == MODE_IMMEDIATE) begin
						next_s.disable_out = 1'b1; // [R14] [R6] [R7]
						next_s.interval_done = 1'b0;
						next_s.st = (retry_mode == RETRY_FOREVER) ? ST_RETRY_WAIT : ST_LATCHED;
					end
				end
			end
			ST_DEGLITCH: begin
				if (!ov_detect_i) begin
					next_s.st = ST_RUN;
				end else if (dgl_done) begin
					next_s.disable_out = 1'b1; // [R8] [R9]
					next_s.interval_done = 1'b0;
					next_s.st = (retry_mode == RETRY_FOREVER) ? ST_RETRY_WAIT : ST_LATCHED;
				end
			end
			ST_LATCHED: begin
				next_s.disable_out = 1'b1; // [R15]
				if (off_to_on) begin
					next_s.st = ST_RUN;
				end
			end
			ST_RETRY_WAIT: begin
				if (other_latch_fault_i) begin
					next_s.st = ST_LATCHED; // [R7]
				end else if (!output_commanded_on_i) begin
					next_s.st = ST_RUN;
				end else if ((s.interval_done || rty_done)
					&& (output_decayed_i || !decay_check_en_i)) begin
					next_s.restart = 1'b1; // [R16] [R18]
					next_s.disable_out = 1'b0;
					next_s.st = ST_RUN;
				end
			end
		endcase
		if (!output_commanded_on_i && s.st == ST_RUN) begin
			next_s.disable_out = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			// The on-command edge detector starts high, so a pin already high at reset is no off-then-on.
			s <= '{resp: RESP_RESET, st: ST_RUN, cmd_on_d: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// Clamp acts combinationally from the comparator so the pull-down is not delayed.
	always_comb begin
		overvoltage_low_side_clamp_o = (resp_mode == MODE_CLAMP) && ov_detect_i; // [R5]
		power_o.bottom_force_on = overvoltage_low_side_clamp_o;
		power_o.top_on_en = !overvoltage_low_side_clamp_o && !s.disable_out;
		power_o.output_disable = s.disable_out;
		power_o.restart_pulse = s.restart;
	end

	assign output_overvoltage_response_o = s.resp;
	assign flags_o = s.flags;
	assign alert_o = s.alert;
	assign cml_fault_o = s.cml;

	flags_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R1] [R4]
		ov_detect_i |=> flags_o == 3'b111 && alert_o)
		else $error("fault did not set flags and alert");
	bad_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R10]
		resp_wr_i && !wr_valid |=> cml_fault_o && $stable(output_overvoltage_response_o))
		else $error("bad write not refused");
	top_two_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R11]
		resp_wr_i && resp_wdata_i[7:6] == 2'b11 |=> cml_fault_o)
		else $error("unsupported field not flagged");
	flag_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R12]
		flags_o.status_vout_ov && !clear_faults_i && !off_to_on |=> flags_o.status_vout_ov)
		else $error("flag dropped without clear");
	clamp_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R5]
		resp_mode == MODE_CLAMP && ov_detect_i |-> power_o.bottom_force_on && !power_o.top_on_en)
		else $error("clamp not driven");
	immediate_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R14]
		s.st == ST_RUN && ov_detect_i && output_commanded_on_i && resp_mode == MODE_IMMEDIATE
		|=> power_o.output_disable)
		else $error("immediate shutdown missed");
	no_retry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R15]
		s.st == ST_LATCHED |-> !power_o.restart_pulse)
		else $error("restart while latched");
	decay_wait_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R18]
		power_o.restart_pulse |-> $past(output_decayed_i) || !$past(decay_check_en_i))
		else $error("restart before decay");
	dgl_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R13]
		s.st == ST_RUN && ov_detect_i && output_commanded_on_i && resp_mode == MODE_DEGLITCH
		|=> !power_o.output_disable)
		else $error("deglitch shut down early");
	other_latch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // [R7]
		s.st == ST_RETRY_WAIT && other_latch_fault_i
		|=> s.st == ST_LATCHED && power_o.output_disable)
		else $error("other fault did not latch off");
endmodule : ov_fault_response
`default_nettype wire

// File: hdl/ov_resp_pkg.sv
// Constants, types and rule summary for the output overvoltage fault response block.
// Function
// [R1] Overvoltage fault sets the overvoltage flag in the top-level status byte.
// [R2] Overvoltage fault sets the output-voltage summary flag in the status word upper byte.
// [R3] Overvoltage fault sets the overvoltage flag in the output-voltage status register.
// [R4] Every overvoltage fault drives the alert output active, whatever the response.
// [R5] Setting 0x00: clamp only, top off and bottom on while above limit.
// [R6] Setting 0x80: disable output on fault, never restart automatically.
// [R7] Setting 0xb8: disable output, retry forever until off, bias loss or latching fault.
// [R8] Setting 0x4n: latch off after fault persists n times 10 us.
// [R9] Setting 0x78+n: shut down after n times 10 us, then retry continuously.
// [R10] Unrecognised setting writes are ignored and raise a communication/memory/logic fault.
// [R11] Response field 11 is unsupported and raises a communication/memory/logic fault.
// [R12] Overvoltage flags hold until clear-faults, off-then-on, or bias cycle.
// [R13] Response 01 keeps running for the delay, then follows the retry field.
// [R14] Response 10 disables output at once, then follows the retry field.
// [R15] Retry 000 never restarts; retry 111 restarts without limit.
// [R16] Restart attempts are spaced by the retry interval setting.
// [R17] Delay field counts 10 us units and applies only to deglitched response.
// [R18] Retry wait lasts the longer of retry interval and output decay unless disabled.
package ov_resp_pkg;

	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned DELAY_UNIT_NS = 10_000;
	localparam int unsigned DELAY_UNIT_CYC = (DELAY_UNIT_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned RETRY_UNIT_CYC = DELAY_UNIT_CYC;
	localparam logic [7:0] RESP_RESET = 8'hb8;
	localparam logic [7:0] RESP_CLAMP = 8'h00;
	localparam logic [7:0] RESP_LATCH = 8'h80;
	localparam logic [7:0] RESP_RETRY = 8'hb8;
	localparam logic [4:0] RESP_DGL_LATCH_HI = 5'h08;
	localparam logic [4:0] RESP_DGL_RETRY_HI = 5'h0f;
	localparam int unsigned RESP_FIELD_MSB = 7;
	localparam int unsigned RETRY_FIELD_MSB = 5;
	localparam int unsigned DELAY_FIELD_MSB = 2;
	localparam logic [1:0] MODE_CLAMP = 2'h0;
	localparam logic [1:0] MODE_DEGLITCH = 2'h1;
	localparam logic [1:0] MODE_IMMEDIATE = 2'h2;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;

	typedef enum {ST_RUN, ST_DEGLITCH, ST_LATCHED, ST_RETRY_WAIT} ov_state_t;

	typedef struct packed {
		logic status_byte_ov;
		logic status_word_vout;
		logic status_vout_ov;
	} ov_flags_t;

	typedef struct packed {
		logic top_on_en;
		logic bottom_force_on;
		logic output_disable;
		logic restart_pulse;
	} power_ctl_t;

endpackage : ov_resp_pkg

// File: hdl/ov_unit_timer.sv
// Down counter that measures a programmed number of time units.
`timescale 1ns/1ps
`default_nettype none
module ov_unit_timer
	import ov_resp_pkg::*;
#(
	parameter int unsigned UNIT_CYC = 400,
	parameter int unsigned COUNT_W = 24
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic [COUNT_W-1:0] units_i,
	output logic done_o,
	output logic busy_o
);
	typedef struct packed {
		logic [COUNT_W-1:0] units;
		logic [15:0] cyc;
		logic busy;
		logic done;
	} tmr_state_t;

	tmr_state_t s;
	tmr_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (start_i) begin
			next_s.units = units_i;
			next_s.cyc = 16'(UNIT_CYC - 1);
			next_s.busy = (units_i != '0);
			next_s.done = (units_i == '0);
		end else if (s.busy) begin
			if (s.cyc != 16'h0000) begin
				next_s.cyc = s.cyc - 16'h0001;
			end else if (s.units == COUNT_W'(1)) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.units = s.units - COUNT_W'(1);
				next_s.cyc = 16'(UNIT_CYC - 1);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done_o = s.done;
	assign busy_o = s.busy;
endmodule : ov_unit_timer
`default_nettype wire

// File: tb/output_stage_model.sv
// Behavioural output rail that decays some cycles after the output is disabled.
`timescale 1ns/1ps
`default_nettype none
module output_stage_model #(
	parameter int unsigned DECAY_CYC = 600
) (
	input wire logic clk_sys_i,
	input wire logic output_disable_i,
	output logic output_decayed_o
);
	int unsigned cnt = 0;
	// The decay is slower than the retry interval on purpose, so the longer wait must win.
	always @(posedge clk_sys_i) begin
		cnt <= output_disable_i ? ((cnt < DECAY_CYC) ? cnt + 1 : cnt) : 0;
	end
	assign output_decayed_o = (cnt >= DECAY_CYC);
endmodule : output_stage_model
`default_nettype wire

// File: tb/ov_fault_response_bench.sv
// Self-checking bench for the output overvoltage fault response block.
`timescale 1ns/1ps
`default_nettype none
module ov_fault_response_bench;
	import ov_resp_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic wr = 1'b0;
	logic [7:0] wd = 8'h00;
	logic [23:0] iv = 24'h000001;
	logic dec_en = 1'b1;
	logic decayed;
	logic ov = 1'b0;
	logic clr = 1'b0;
	logic on = 1'b1;
	logic olf = 1'b0;
	logic [7:0] resp;
	ov_flags_t flags;
	logic alert;
	logic cml;
	power_ctl_t pwr;
	logic clamp;
	int n_mismatch = 0;
	int total_checks = 0;

	always #12.5 clk_sys_i = ~clk_sys_i;

	ov_fault_response #(.RETRY_W(24)) ov_fault_response_i (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .resp_wr_i(wr), .resp_wdata_i(wd),
		.retry_interval_setting_i(iv), .decay_check_en_i(dec_en), .output_decayed_i(decayed),
		.ov_detect_i(ov), .clear_faults_i(clr), .output_commanded_on_i(on),
		.other_latch_fault_i(olf), .output_overvoltage_response_o(resp), .flags_o(flags),
		.alert_o(alert), .cml_fault_o(cml), .power_o(pwr), .overvoltage_low_side_clamp_o(clamp)
	);
	output_stage_model output_stage_model_i (
		.clk_sys_i(clk_sys_i), .output_disable_i(pwr.output_disable), .output_decayed_o(decayed)
	);

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : cyc

	task automatic tally_and_finish();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic write_resp(input logic [7:0] v);
		logic [7:0] old;
		logic ok;
		old = resp;
		ok = (v == 8'h00) || (v == 8'h80) || (v == 8'hb8) || (v[7:3] == 5'h08) || (v[7:3] == 5'h0f);
		@(posedge clk_sys_i);
		wr <= 1'b1;
		wd <= v;
		@(posedge clk_sys_i);
		wr <= 1'b0;
		#1;
		check("stored setting", resp, ok ? v : old);
		check("refusal pulse", {7'h00, cml}, {7'h00, !ok});
	endtask : write_resp

	// One-cycle overvoltage pulse; returns just after the edge that saw it.
	task automatic ov_pulse();
		@(posedge clk_sys_i);
		ov <= 1'b1;
		@(posedge clk_sys_i);
		ov <= 1'b0;
		#1;
	endtask : ov_pulse

	task automatic off_on();
		@(posedge clk_sys_i);
		on <= 1'b0;
		@(posedge clk_sys_i);
		on <= 1'b1;
		cyc(3);
		#1;
		check("flags after off-on", {5'h00, flags}, 8'h00);
		check("disable after off-on", {7'h00, pwr.output_disable}, 8'h00);
	endtask : off_on

	task automatic t_settings();
		logic [7:0] tbl [13] = '{8'h00, 8'h80, 8'h40, 8'h47, 8'h78, 8'h7f, 8'hc0, 8'hff,
			8'h81, 8'h48, 8'h77, 8'hb9, 8'hb8};
		check("reset setting", resp, 8'hb8);
		foreach (tbl[i]) write_resp(tbl[i]);
	endtask : t_settings

	task automatic t_latch();
		write_resp(8'h80);
		ov_pulse();
		check("flags", {5'h00, flags}, 8'h07);
		check("alert", {7'h00, alert}, 8'h01);
		check("disable", {7'h00, pwr.output_disable}, 8'h01);
		cyc(50);
		@(posedge clk_sys_i);
		clr <= 1'b1;
		@(posedge clk_sys_i);
		clr <= 1'b0;
		#1;
		check("disable held", {7'h00, pwr.output_disable}, 8'h01);
		check("flags cleared", {5'h00, flags}, 8'h00);
		check("alert cleared", {7'h00, alert}, 8'h00);
		off_on();
	endtask : t_latch

	task automatic t_clamp();
		write_resp(8'h00);
		@(posedge clk_sys_i);
		ov <= 1'b1;
		cyc(3);
		#1;
		check("clamp", {clamp, pwr.bottom_force_on, pwr.top_on_en}, 8'h06);
		check("no disable", {7'h00, pwr.output_disable}, 8'h00);
		check("alert", {7'h00, alert}, 8'h01);
		@(posedge clk_sys_i);
		ov <= 1'b0;
		cyc(2);
		#1;
		check("clamp off", {clamp, pwr.bottom_force_on, pwr.top_on_en}, 8'h01);
		off_on();
	endtask : t_clamp

	// One delay unit is 400 cycles; the fault must outlast it before shutdown.
	task automatic t_deglitch();
		write_resp(8'h41);
		@(posedge clk_sys_i);
		ov <= 1'b1;
		cyc(200);
		ov <= 1'b0;
		cyc(3);
		#1;
		check("short fault", {7'h00, pwr.output_disable}, 8'h00);
		@(posedge clk_sys_i);
		ov <= 1'b1;
		cyc(360);
		#1;
		check("still running", {7'h00, pwr.output_disable}, 8'h00);
		cyc(60);
		ov <= 1'b0;
		#1;
		check("deglitched off", {7'h00, pwr.output_disable}, 8'h01);
		cyc(1500);
		#1;
		check("no retry", {7'h00, pwr.output_disable}, 8'h01);
		off_on();
	endtask : t_deglitch

	// The fault is held for hold cycles, so a deglitched setting with n=0 also reaches shutdown.
	task automatic t_retry(input logic den, input int hold, input int lo, input int hi);
		int i;
		@(posedge clk_sys_i);
		dec_en <= den;
		ov <= 1'b1;
		cyc(hold);
		ov <= 1'b0;
		#1;
		check("retry disable", {7'h00, pwr.output_disable}, 8'h01);
		for (i = 0; i < 2000 && pwr.restart_pulse !== 1'b1; i++) begin
			@(posedge clk_sys_i);
			#1;
		end
		check("retry wait", {7'h00, i >= lo && i <= hi}, 8'h01);
		check("enabled at restart", {7'h00, pwr.output_disable}, 8'h00);
		cyc(1);
		#1;
		check("restart pulse width", {7'h00, pwr.restart_pulse}, 8'h00);
	endtask : t_retry

	// A non-retry fault during the retry wait must keep the output off past the interval.
	task automatic t_other_latch();
		ov_pulse();
		cyc(5);
		olf <= 1'b1;
		@(posedge clk_sys_i);
		olf <= 1'b0;
		cyc(800);
		#1;
		check("latched by other fault", {7'h00, pwr.output_disable}, 8'h01);
		check("no restart after other fault", {7'h00, pwr.restart_pulse}, 8'h00);
		off_on();
	endtask : t_other_latch

	initial begin
		cyc(12);
		rst_b_i <= 1'b1;
		t_settings();
		t_latch();
		t_clamp();
		t_deglitch();
		write_resp(8'hb8);
		t_retry(1'b1, 1, 598, 640);
		t_retry(1'b0, 1, 398, 420);
		t_other_latch();
		write_resp(8'h78);
		t_retry(1'b0, 2, 398, 420);
		tally_and_finish();
	end

	initial begin
		cyc(20000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule : ov_fault_response_bench
`default_nettype wire
